// File: verilog/otp_prog_cfg.svh
// Purpose: constants for the one-time-programmable memory programmer
// Assumes: a 250 MHz system clock
// Notes: times are kept in ns; cycle counts derive from them
`ifndef OTP_PROG_CFG_SVH
`define OTP_PROG_CFG_SVH

`define CLK_MHZ 250
// Least time rounded up to whole cycles, never below one cycle
`define CYC_UP(ns) ((((ns) * `CLK_MHZ + 999) / 1000) < 1 ? 1 : \
	(((ns) * `CLK_MHZ + 999) / 1000))

// Nominal program pulse, legal window 47500 to 52500 ns
`define PULSE_NS 50000
`define PULSE_CYC ((`PULSE_NS * `CLK_MHZ) / 1000)
// Address, data, strobe and supply setup and data hold
`define SETUP_NS 2000
`define SETUP_CYC `CYC_UP(`SETUP_NS)
// Output drive to data valid during verify
`define OUT_VALID_NS 150
`define OUT_VALID_CYC `CYC_UP(`OUT_VALID_NS)
// Output drive release to data lines floating
`define OUT_FLOAT_NS 130
`define OUT_FLOAT_CYC `CYC_UP(`OUT_FLOAT_NS)

`define RETRY_MAX 4'hA
`define FIRST_ADDR 18'h00000
`define LAST_ADDR 18'h3FFFF
`define TCOUNT_W 14

`endif

// File: verilog/otp_prog_pkg.sv
// Purpose: shared types for the memory programmer
// Assumes: otp_prog_cfg.svh holds the numbers
// Notes: state codes step by one bit from idle to done, but not on the jumps back to fetch and setup
`include "otp_prog_cfg.svh"

package otp_prog_pkg;
	typedef logic [17:0] addr_t;
	typedef logic [15:0] word_t;
	typedef logic [`TCOUNT_W-1:0] tcount_t;
	typedef logic [3:0] retry_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_RAMP = 4'h1,
		ST_FETCH = 4'h3,
		ST_SETUP = 4'h2,
		ST_PULSE = 4'h6,
		ST_HOLD = 4'h7,
		ST_VREAD = 4'h5,
		ST_VREL = 4'h4,
		ST_NEXT = 4'hC,
		ST_SUPPLY = 4'hD,
		ST_DONE = 4'hF,
		ST_ID_RD = 4'hE,
		ST_ID_REL = 4'hA
	} state_t;
endpackage

// File: verilog/timer_if.sv
// Purpose: link between the sequencer and its wait timer
// Assumes: load is a one-cycle request
// Notes: expired stays high until the next load
`timescale 1ns/100ps
`default_nettype none

interface timer_if;
	logic load;
	otp_prog_pkg::tcount_t count;
	logic expired;

	modport ctl (output load, output count, input expired);
	modport tmr (input load, input count, output expired);
endinterface

`default_nettype wire

// File: verilog/prog_timer.sv
// Purpose: down counter that times every wait of the sequencer
// Assumes: count is at least one when loaded
// Notes: expires count plus one cycles after the load cycle
`timescale 1ns/100ps
`default_nettype none

module prog_timer (
	// Clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	// Sequencer side
	timer_if.tmr tif
);
	otp_prog_pkg::tcount_t cnt_r;
	otp_prog_pkg::tcount_t cnt_nxt;

	// Reload on request, else run down to zero and stop
	always_comb begin
		cnt_nxt = cnt_r;
		if (tif.load) begin
			cnt_nxt = tif.count;
		end else if (cnt_r != '0) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// Freezes with the clock enable so waits stretch, never shrink
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= '0;
		end else if (i_clk_en) begin
			cnt_r <= cnt_nxt;
		end
	end

	assign tif.expired = (cnt_r == '0);
endmodule

`default_nettype wire

// File: verilog/otp_programmer.sv
// Purpose: programs, verifies and identifies a 256K x 16 OTP memory
// Assumes: supplies switched by level outputs; source answers with ack
// Notes: data bus is split into in, out and output enable
// Summary of operation
// - Each chip-select program pulse lasts nominally 50 us, 47.5 to 52.5.
// - Start at first address with core 6.5 V and program supply 13 V.
// - Every address first gets one nominal pulse with no verify read.
// - On verify failure, pulse again, up to ten, verifying after each.
// - Still failing after ten extra pulses marks the whole device failed.
// - A verified word advances the address until all are checked.
// - Then both supplies go to 5 V and every word is compared again.
// - Wait 150 ns after output drive to sample, 130 ns after release.
`timescale 1ns/100ps
`default_nettype none
`include "otp_prog_cfg.svh"

module otp_programmer #(
	parameter int unsigned P_PULSE_CYC = `PULSE_CYC,
	parameter otp_prog_pkg::addr_t P_LAST_ADDR = `LAST_ADDR
) (
	// Clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	// User commands and status
	input wire logic i_prog_start,
	input wire logic i_id_start,
	output logic o_busy,
	output logic o_done,
	output logic o_pass,
	output logic o_fail,
	output logic [15:0] o_id_maker,
	output logic [15:0] o_id_type,
	// Word source
	output logic o_src_req,
	input wire logic i_src_ack,
	input wire logic [15:0] i_src_word,
	// Memory pins
	output logic [17:0] o_addr,
	output logic o_ce_n,
	output logic o_oe_n,
	output logic [15:0] o_dq,
	output logic o_dq_oe,
	input wire logic [15:0] i_dq,
	// Supply and identification voltage controls
	output logic o_vcc_prog,
	output logic o_vpp_prog,
	output logic o_id_volt
);
	localparam otp_prog_pkg::tcount_t C_SETUP =
		otp_prog_pkg::tcount_t'(`SETUP_CYC);
	localparam otp_prog_pkg::tcount_t C_VALID =
		otp_prog_pkg::tcount_t'(`OUT_VALID_CYC);
	localparam otp_prog_pkg::tcount_t C_FLOAT =
		otp_prog_pkg::tcount_t'(`OUT_FLOAT_CYC);
	// The sequencer acts one cycle after expiry, so the pulse loads one less
	localparam otp_prog_pkg::tcount_t C_PULSE =
		otp_prog_pkg::tcount_t'(P_PULSE_CYC - 1);

	timer_if tif ();

	prog_timer u_timer (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_clk_en(i_clk_en),
		.tif(tif)
	);

	otp_prog_pkg::state_t state_r, state_nxt;
	otp_prog_pkg::addr_t addr_r, addr_nxt;
	otp_prog_pkg::word_t word_r, word_nxt;
	otp_prog_pkg::word_t dq_r, dq_nxt;
	otp_prog_pkg::word_t maker_r, maker_nxt;
	otp_prog_pkg::word_t type_r, type_nxt;
	otp_prog_pkg::retry_t retry_r, retry_nxt;
	logic ce_n_r, ce_n_nxt;
	logic oe_n_r, oe_n_nxt;
	logic dq_oe_r, dq_oe_nxt;
	logic vcc_r, vcc_nxt;
	logic vpp_r, vpp_nxt;
	logic idv_r, idv_nxt;
	logic req_r, req_nxt;
	logic busy_r, busy_nxt;
	logic done_r, done_nxt;
	logic pass_r, pass_nxt;
	logic fail_r, fail_nxt;
	logic final_r, final_nxt;
	logic match_r, match_nxt;

	// Sequencer: every state waits on the timer except idle, fetch, next and done
	always_comb begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		word_nxt = word_r;
		dq_nxt = dq_r;
		maker_nxt = maker_r;
		type_nxt = type_r;
		retry_nxt = retry_r;
		ce_n_nxt = ce_n_r;
		oe_n_nxt = oe_n_r;
		dq_oe_nxt = dq_oe_r;
		vcc_nxt = vcc_r;
		vpp_nxt = vpp_r;
		idv_nxt = idv_r;
		req_nxt = req_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		pass_nxt = pass_r;
		fail_nxt = fail_r;
		final_nxt = final_r;
		match_nxt = match_r;
		tif.load = 1'b0;
		tif.count = C_SETUP;
		case (state_r)
			otp_prog_pkg::ST_IDLE: begin
				if (i_prog_start) begin
					// Core supply first; program supply follows after setup
					vcc_nxt = 1'b1;
					addr_nxt = `FIRST_ADDR;
					busy_nxt = 1'b1;
					pass_nxt = 1'b0;
					fail_nxt = 1'b0;
					final_nxt = 1'b0;
					tif.load = 1'b1;
					state_nxt = otp_prog_pkg::ST_RAMP;
				end else if (i_id_start) begin
					idv_nxt = 1'b1;
					addr_nxt = `FIRST_ADDR;
					ce_n_nxt = 1'b0;
					oe_n_nxt = 1'b0;
					dq_oe_nxt = 1'b0;
					busy_nxt = 1'b1;
					tif.load = 1'b1;
					tif.count = C_VALID;
					state_nxt = otp_prog_pkg::ST_ID_RD;
				end
			end
			otp_prog_pkg::ST_RAMP: begin
				if (tif.expired) begin
					vpp_nxt = 1'b1;
					req_nxt = 1'b1;
					state_nxt = otp_prog_pkg::ST_FETCH;
				end
			end
			otp_prog_pkg::ST_FETCH: begin
				if (i_src_ack) begin
					req_nxt = 1'b0;
					word_nxt = i_src_word;
					retry_nxt = '0;
					tif.load = 1'b1;
					if (final_r) begin
						// Last pass reads only, at normal supplies
						ce_n_nxt = 1'b0;
						oe_n_nxt = 1'b0;
						tif.count = C_VALID;
						state_nxt = otp_prog_pkg::ST_VREAD;
					end else begin
						// First pulse goes out before any verify
						dq_nxt = i_src_word;
						dq_oe_nxt = 1'b1;
						state_nxt = otp_prog_pkg::ST_SETUP;
					end
				end
			end
			otp_prog_pkg::ST_SETUP: begin
				if (tif.expired) begin
					ce_n_nxt = 1'b0;
					tif.load = 1'b1;
					tif.count = C_PULSE;
					state_nxt = otp_prog_pkg::ST_PULSE;
				end
			end
			otp_prog_pkg::ST_PULSE: begin
				if (tif.expired) begin
					ce_n_nxt = 1'b1;
					tif.load = 1'b1;
					state_nxt = otp_prog_pkg::ST_HOLD;
				end
			end
			otp_prog_pkg::ST_HOLD: begin
				if (tif.expired) begin
					// Bus released in the same edge the memory is told to drive
					dq_oe_nxt = 1'b0;
					ce_n_nxt = 1'b0;
					oe_n_nxt = 1'b0;
					tif.load = 1'b1;
					tif.count = C_VALID;
					state_nxt = otp_prog_pkg::ST_VREAD;
				end
			end
			otp_prog_pkg::ST_VREAD: begin
				if (tif.expired) begin
					match_nxt = (i_dq == word_r);
					ce_n_nxt = 1'b1;
					oe_n_nxt = 1'b1;
					tif.load = 1'b1;
					tif.count = C_FLOAT;
					state_nxt = otp_prog_pkg::ST_VREL;
				end
			end
			otp_prog_pkg::ST_VREL: begin
				if (tif.expired) begin
					if (match_r) begin
						state_nxt = otp_prog_pkg::ST_NEXT;
					end else if (final_r) begin
						fail_nxt = 1'b1;
						state_nxt = otp_prog_pkg::ST_DONE;
					end else if (retry_r == `RETRY_MAX) begin
						// Supplies come down before reporting
						fail_nxt = 1'b1;
						vpp_nxt = 1'b0;
						tif.load = 1'b1;
						state_nxt = otp_prog_pkg::ST_SUPPLY;
					end else begin
						retry_nxt = retry_r + 1'b1;
						dq_oe_nxt = 1'b1;
						tif.load = 1'b1;
						state_nxt = otp_prog_pkg::ST_SETUP;
					end
				end
			end
			otp_prog_pkg::ST_NEXT: begin
				if (addr_r != P_LAST_ADDR) begin
					addr_nxt = addr_r + 1'b1;
					req_nxt = 1'b1;
					state_nxt = otp_prog_pkg::ST_FETCH;
				end else if (final_r) begin
					pass_nxt = 1'b1;
					state_nxt = otp_prog_pkg::ST_DONE;
				end else begin
					vpp_nxt = 1'b0;
					tif.load = 1'b1;
					state_nxt = otp_prog_pkg::ST_SUPPLY;
				end
			end
			otp_prog_pkg::ST_SUPPLY: begin
				// Program supply drops first, core supply after it
				if (tif.expired) begin
					if (vcc_r) begin
						vcc_nxt = 1'b0;
						tif.load = 1'b1;
					end else if (fail_r) begin
						state_nxt = otp_prog_pkg::ST_DONE;
					end else begin
						final_nxt = 1'b1;
						addr_nxt = `FIRST_ADDR;
						req_nxt = 1'b1;
						state_nxt = otp_prog_pkg::ST_FETCH;
					end
				end
			end
			otp_prog_pkg::ST_DONE: begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
				state_nxt = otp_prog_pkg::ST_IDLE;
			end
			otp_prog_pkg::ST_ID_RD: begin
				if (tif.expired) begin
					if (addr_r[0]) begin
						type_nxt = i_dq;
					end else begin
						maker_nxt = i_dq;
					end
					ce_n_nxt = 1'b1;
					oe_n_nxt = 1'b1;
					tif.load = 1'b1;
					tif.count = C_FLOAT;
					state_nxt = otp_prog_pkg::ST_ID_REL;
				end
			end
			otp_prog_pkg::ST_ID_REL: begin
				if (tif.expired) begin
					if (addr_r[0]) begin
						idv_nxt = 1'b0;
						addr_nxt = `FIRST_ADDR;
						state_nxt = otp_prog_pkg::ST_DONE;
					end else begin
						addr_nxt = addr_r | 18'h00001;
						ce_n_nxt = 1'b0;
						oe_n_nxt = 1'b0;
						tif.load = 1'b1;
						tif.count = C_VALID;
						state_nxt = otp_prog_pkg::ST_ID_RD;
					end
				end
			end
			default: begin
				state_nxt = otp_prog_pkg::ST_IDLE;
			end
		endcase
	end

	// Registers only; strobes idle high, supplies at normal level
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= otp_prog_pkg::ST_IDLE;
			addr_r <= `FIRST_ADDR;
			word_r <= 16'h0000;
			dq_r <= 16'h0000;
			maker_r <= 16'h0000;
			type_r <= 16'h0000;
			retry_r <= 4'h0;
			ce_n_r <= 1'b1;
			oe_n_r <= 1'b1;
			dq_oe_r <= 1'b0;
			vcc_r <= 1'b0;
			vpp_r <= 1'b0;
			idv_r <= 1'b0;
			req_r <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			pass_r <= 1'b0;
			fail_r <= 1'b0;
			final_r <= 1'b0;
			match_r <= 1'b0;
		end else if (i_clk_en) begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
			word_r <= word_nxt;
			dq_r <= dq_nxt;
			maker_r <= maker_nxt;
			type_r <= type_nxt;
			retry_r <= retry_nxt;
			ce_n_r <= ce_n_nxt;
			oe_n_r <= oe_n_nxt;
			dq_oe_r <= dq_oe_nxt;
			vcc_r <= vcc_nxt;
			vpp_r <= vpp_nxt;
			idv_r <= idv_nxt;
			req_r <= req_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			pass_r <= pass_nxt;
			fail_r <= fail_nxt;
			final_r <= final_nxt;
			match_r <= match_nxt;
		end
	end

	// Outputs straight from flops
	assign o_busy = busy_r;
	assign o_done = done_r;
	assign o_pass = pass_r;
	assign o_fail = fail_r;
	assign o_id_maker = maker_r;
	assign o_id_type = type_r;
	assign o_src_req = req_r;
	assign o_addr = addr_r;
	assign o_ce_n = ce_n_r;
	assign o_oe_n = oe_n_r;
	assign o_dq = dq_r;
	assign o_dq_oe = dq_oe_r;
	assign o_vcc_prog = vcc_r;
	assign o_vpp_prog = vpp_r;
	assign o_id_volt = idv_r;
endmodule

`default_nettype wire

// File: sim/otp_programmer_assertions.sv
// Purpose: timing checks on the programmer pins
// Assumes: one clock domain, reset asynchronous active high
// Notes: pulse counts are kept per address in helper logic
`timescale 1ns/100ps
`default_nettype none

module otp_programmer_chk #(
	parameter int unsigned P_PULSE_CYC = 20,
	parameter otp_prog_pkg::addr_t P_LAST_ADDR = 18'h00003
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// Watched outputs
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_pass,
	input wire logic o_fail,
	input wire logic [17:0] o_addr,
	input wire logic o_ce_n,
	input wire logic o_oe_n,
	input wire logic o_dq_oe,
	input wire logic o_vcc_prog,
	input wire logic o_vpp_prog,
	input wire logic o_id_volt
);
	logic [15:0] pw_r, pw_nxt;
	logic [4:0] np_r, np_nxt;
	logic [17:0] pa_r;

	// Pulse length and pulses per address; a new address restarts count
	always_comb begin
		pw_nxt = (!o_ce_n && o_oe_n) ? pw_r + 16'h0001 : 16'h0000;
		np_nxt = (o_addr != pa_r) ? 5'h00 : np_r;
		if (!o_ce_n && o_oe_n && pw_r == 16'h0000) begin
			np_nxt = np_nxt + 5'h01;
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			pw_r <= 16'h0000;
			np_r <= 5'h00;
			pa_r <= 18'h00000;
		end else begin
			pw_r <= pw_nxt;
			np_r <= np_nxt;
			pa_r <= o_addr;
		end
	end

	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	// Output enable still low 38 cycles after it falls and high one cycle later: a 39-cycle read wait
	sequence s_read;
		##38 !o_oe_n ##1 o_oe_n;
	endsequence
	sequence s_float;
		(!o_dq_oe && o_oe_n) throughout (##32 1'b1);
	endsequence

	a_pulse_width: assert property ($rose(o_ce_n) &&
		$past(o_oe_n) && o_oe_n |-> pw_r == P_PULSE_CYC)
		else $error("bad pulse width");
	a_pulse_limit: assert property (np_r <= 5'h0B)
		else $error("too many pulses on one word");
	a_supply_order: assert property (o_vpp_prog |-> o_vcc_prog)
		else $error("program supply without core supply");
	a_start_addr: assert property ($rose(o_vcc_prog) |->
		o_addr == 18'h00000 && o_busy) else $error("bad start");
	a_pulse_drive: assert property (!o_ce_n && o_oe_n |->
		o_dq_oe && o_vpp_prog) else $error("pulse without data");
	a_verify_bus: assert property (!o_oe_n |-> !o_dq_oe)
		else $error("bus driven during read");
	a_read_wait: assert property ($fell(o_oe_n) |-> s_read)
		else $error("read wait wrong");
	a_float_wait: assert property ($rose(o_oe_n) |-> s_float)
		else $error("bus driven before float");
	a_done_pulse: assert property (o_done |->
		!o_busy && !(o_pass && o_fail) ##1 !o_done) else $error("bad done");
	a_id_levels: assert property (o_id_volt |->
		!o_vcc_prog && !o_vpp_prog) else $error("id at raised supply");
endmodule

bind otp_programmer otp_programmer_chk #(.P_PULSE_CYC(P_PULSE_CYC),
	.P_LAST_ADDR(P_LAST_ADDR)) u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
	.o_busy(o_busy), .o_done(o_done), .o_pass(o_pass), .o_fail(o_fail),
	.o_addr(o_addr), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_dq_oe(o_dq_oe),
	.o_vcc_prog(o_vcc_prog), .o_vpp_prog(o_vpp_prog),
	.o_id_volt(o_id_volt));

`default_nettype wire

// File: sim/otp_mem_model.sv
// Purpose: four-word behavioural model of the memory
// Assumes: bench sets need, cnt, mem and flip before each run
// Notes: weak words take several pulses before they hold
`timescale 1ns/100ps
`default_nettype none

module otp_mem_model #(
	parameter logic [15:0] P_MAKER = 16'h0011, // Arbitrary value
	parameter logic [15:0] P_TYPE = 16'h0022 // Arbitrary value
) (
	// Memory pins
	input wire logic [17:0] i_addr,
	input wire logic i_ce_n,
	input wire logic i_oe_n,
	input wire logic [15:0] i_dq,
	// Supplies
	input wire logic i_vpp,
	input wire logic i_id_volt,
	// Read data
	output logic [15:0] o_dq
);
	logic [15:0] mem [0:3];
	int cnt [0:3];
	int need [0:3];
	logic [15:0] flip;
	logic ok;
	logic [15:0] val;

	initial ok = 1'b0;
	// A word holds only after its count of pulses at raised supply
	always @(negedge i_ce_n) begin
		#1; // Strobes falling together in one step must not look like a pulse
		if (!i_ce_n && i_oe_n && i_vpp) begin
			cnt[i_addr[1:0]]++;
			if (cnt[i_addr[1:0]] >= need[i_addr[1:0]]) begin
				mem[i_addr[1:0]] = i_dq;
			end
		end
	end
	// Data valid 100 ns after output drive, inside the allowance
	always @(negedge i_oe_n) begin
		#100 ok = !i_oe_n;
	end
	always @(posedge i_oe_n) ok = 1'b0;
	// Low address bit picks the code; flip models a weak read at 5 V
	assign val = i_id_volt ? (i_addr[0] ? P_TYPE : P_MAKER) :
		mem[i_addr[1:0]] ^ (i_vpp ? 16'h0000 : flip);
	// Idle bus shows the inverse so a stale sample cannot pass
	assign o_dq = (ok && !i_ce_n) ? val : ~val;
endmodule

`default_nettype wire

// File: sim/otp_programmer_tb_top.sv
// Purpose: scenario bench for the memory programmer
// Assumes: four-word memory, short program pulse
// Notes: source answers each request with a one-cycle ack
`timescale 1ns/100ps
`default_nettype none

module otp_programmer_tb_top;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic i_clk_en = 1'b1;
	logic i_prog_start = 1'b0;
	logic i_id_start = 1'b0;
	logic i_src_ack = 1'b0;
	logic [15:0] i_src_word = 16'h0000;
	logic [15:0] i_dq, mem_dq, o_dq, o_id_maker, o_id_type;
	logic [17:0] o_addr;
	logic o_busy, o_done, o_pass, o_fail, o_src_req, o_ce_n, o_oe_n;
	logic o_dq_oe, o_vcc_prog, o_vpp_prog, o_id_volt;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;

	otp_programmer #(.P_PULSE_CYC(20), .P_LAST_ADDR(18'h00003)) DUT (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_clk_en(i_clk_en),
		.i_prog_start(i_prog_start), .i_id_start(i_id_start),
		.o_busy(o_busy), .o_done(o_done), .o_pass(o_pass), .o_fail(o_fail),
		.o_id_maker(o_id_maker), .o_id_type(o_id_type),
		.o_src_req(o_src_req), .i_src_ack(i_src_ack),
		.i_src_word(i_src_word), .o_addr(o_addr), .o_ce_n(o_ce_n),
		.o_oe_n(o_oe_n), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_dq(i_dq),
		.o_vcc_prog(o_vcc_prog), .o_vpp_prog(o_vpp_prog),
		.o_id_volt(o_id_volt));

	otp_mem_model mem_m (.i_addr(o_addr), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n),
		.i_dq(o_dq), .i_vpp(o_vpp_prog), .i_id_volt(o_id_volt),
		.o_dq(mem_dq));

	// Bus resolution: the programmer wins while it drives
	assign i_dq = o_dq_oe ? o_dq : mem_dq;

	always #2 i_mclk = ~i_mclk;

	function automatic logic [15:0] w(int a);
		return 16'hA5C0 + a[15:0];
	endfunction

	// Word source answers one request with one ack
	always @(negedge i_mclk) begin
		i_src_ack <= o_src_req && !i_src_ack;
		i_src_word <= w(int'(o_addr));
	end

	// Ceiling well above the roughly 45k cycles all runs need
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 80000) begin
			error_cnt++;
			results();
		end
	end

	task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic init(int n2, logic [15:0] f);
		for (int a = 0; a < 4; a++) begin
			mem_m.mem[a] = 16'hFFFF;
			mem_m.cnt[a] = 0;
			mem_m.need[a] = 1;
		end
		mem_m.need[2] = n2;
		mem_m.flip = f;
	endtask

	task automatic run(logic id);
		@(negedge i_mclk);
		i_id_start = id;
		i_prog_start = !id;
		@(negedge i_mclk);
		i_id_start = 1'b0;
		i_prog_start = 1'b0;
		do @(negedge i_mclk); while (o_done !== 1'b1);
	endtask

	task automatic t_id;
		init(1, 16'h0000);
		run(1'b1);
		chk("maker", o_id_maker, mem_m.P_MAKER);
		chk("type", o_id_type, mem_m.P_TYPE);
	endtask

	task automatic t_prog_ok;
		init(1, 16'h0000);
		run(1'b0);
		chk("pass", o_pass, 1);
		chk("fail", o_fail, 0);
		for (int a = 0; a < 4; a++) begin
			chk("word", mem_m.mem[a], w(a));
			chk("pulses", mem_m.cnt[a], 1);
		end
	endtask

	task automatic t_retry;
		init(11, 16'h0000);
		run(1'b0);
		chk("pass", o_pass, 1);
		chk("pulses", mem_m.cnt[2], 11);
	endtask

	task automatic t_fail;
		init(12, 16'h0000);
		run(1'b0);
		chk("fail", o_fail, 1);
		chk("pass", o_pass, 0);
		chk("pulses", mem_m.cnt[2], 11);
		chk("next", mem_m.cnt[3], 0);
	endtask

	// Word programs fine but reads wrong at normal supply
	task automatic t_final;
		init(1, 16'h0100);
		run(1'b0);
		chk("fail", o_fail, 1);
		chk("pass", o_pass, 0);
	endtask

	task automatic results;
		$display("Errors %0d of %0d checks", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (5) @(negedge i_mclk);
		i_rst = 1'b0;
		t_id();
		t_prog_ok();
		t_retry();
		t_fail();
		t_final();
		results();
	end
endmodule

`default_nettype wire
